// ==== logic/sil_cfg.svh ====
// register offsets, field positions and reset values of the interrupt logic
// assumes inclusion by bare name from every file that decodes registers
`ifndef SIL_CFG_SVH
`define SIL_CFG_SVH

// register offsets on the device register port
`define SIL_OFF_PIN_CFG 8'h03
`define SIL_OFF_ENABLE 8'h04
`define SIL_OFF_MODE_PRI 8'h05
`define SIL_OFF_MODE_SEC 8'h06
`define SIL_OFF_FLAGS 8'h10

// reset value shared by every register
`define SIL_RST_REG 8'h00

// writable bits; the rest read as zero
`define SIL_MASK_PIN_CFG 8'h03
`define SIL_MASK_ENABLE 8'h3F
`define SIL_MASK_MODE_PRI 8'hFF
`define SIL_MASK_MODE_SEC 8'h0F
`define SIL_MASK_FLAGS 8'h3F

// pin configuration fields
`define SIL_CFG_OE 0
`define SIL_CFG_RELEASE 1

// flag and enable bit positions
`define SIL_BIT_LIGHT_LEAVE 0
`define SIL_BIT_LIGHT_ENTER 1
`define SIL_BIT_PROX_BASE 2
`define SIL_BIT_CMD 5

// mode field positions
`define SIL_PROX_ONE_LSB 4
`define SIL_PROX_TWO_LSB 6
`define SIL_PROX_THREE_LSB 0
`define SIL_LIGHT_EVERY 3'h0
`define SIL_LIGHT_LEAVE_BIT 0
`define SIL_LIGHT_CH_BIT 1
`define SIL_LIGHT_ENTER_BIT 2
`define SIL_CMD_SEL_BIT 2
`define SIL_RESP_ERR_BIT 7

`endif

// ==== logic/sil_pkg.sv ====
// types shared by the sensor interrupt logic
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package sil_pkg;
  // flag-setting choice of one proximity channel
  typedef enum logic [1:0] {
    SIL_PM_EVERY = 2'b00,
    SIL_PM_CROSS = 2'b01,
    SIL_PM_RSVD = 2'b10,
    SIL_PM_ABOVE = 2'b11
  } sil_prox_mode_t;
  // how the pin is released after assertion
  typedef enum logic [0:0] {
    SIL_REL_HOST = 1'b0,
    SIL_REL_READ = 1'b1
  } sil_release_t;
endpackage
`default_nettype wire

// ==== logic/sil_hist_filter.sv ====
// history filter: flips a condition state after N agreeing samples
// assumes sample strobes and conditions from logic on the same clock
`default_nettype none
module sil_hist_filter #(
  parameter int HW = 4
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // sample and conditions
  input wire logic sample_in,
  input wire logic set_cond_in,
  input wire logic clr_cond_in,
  input wire logic [HW-1:0] hist_len_in,
  // filtered state
  output logic state_out,
  output logic change_out
);
  logic state_reg, state_next;
  logic change_reg, change_next;
  logic [HW-1:0] cnt_reg, cnt_next;
  logic [HW:0] run;

  // a length of zero behaves as one sample
  always_comb begin
    state_next = state_reg;
    change_next = 1'b0;
    cnt_next = cnt_reg;
    run = {1'b0, cnt_reg} + {{HW{1'b0}}, 1'b1};
    if (sample_in) begin
      if (state_reg ? clr_cond_in : set_cond_in) begin
        if (run >= {1'b0, hist_len_in}) begin
          state_next = ~state_reg;
          change_next = 1'b1;
          cnt_next = '0;
        end else begin
          cnt_next = run[HW-1:0];
        end
      end else begin
        cnt_next = '0; // disagreeing run restarts
      end
    end
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg <= 1'b0;
      change_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      change_reg <= change_next;
      cnt_reg <= cnt_next;
    end
  end

  assign state_out = state_reg;
  assign change_out = change_reg;
endmodule
`default_nettype wire

// ==== logic/sil_irq_core.sv ====
// interrupt flags, masks, modes and pin drive of the sensor
// assumes register port and sample strobes are on core_clk_in already
//
// Contract
// - pin driven only while output enable set
// - pin asserts on any enabled set flag
// - release bit picks how pin deasserts
// - release zero: flags hold until host clears
// - writing one clears that flag only
// - flags set only per enables and modes
// - prox one mode 00: flag every sample
// - prox one mode 01: flag on crossing
// - prox one mode 11: flag when above
// - prox two, three share same modes
// - light flags on leaving, entering window
// - command flag on response or error
`default_nettype none
`include "sil_cfg.svh"
module sil_irq_core
  import sil_pkg::*;
#(
  parameter int DW = 16,
  parameter int HW = 4
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // proximity samples, channel n in slice n
  input wire logic [2:0] prox_sample_valid_in,
  input wire logic [3*DW-1:0] prox_sample_in,
  input wire logic [3*DW-1:0] prox_threshold_in,
  input wire logic [DW-1:0] prox_hysteresis_in,
  input wire logic [HW-1:0] prox_history_check_in,
  // ambient light samples, visible 0 and infrared 1
  input wire logic [1:0] light_sample_valid_in,
  input wire logic [2*DW-1:0] light_sample_in,
  input wire logic [DW-1:0] light_low_threshold_in,
  input wire logic [DW-1:0] light_high_threshold_in,
  input wire logic [DW-1:0] light_hysteresis_in,
  input wire logic [HW-1:0] light_history_in,
  // command responses
  input wire logic resp_valid_in,
  input wire logic [7:0] resp_value_in,
  // open-drain interrupt pin
  output logic irq_pin_n_out,
  output logic irq_pin_oe_out
);
  logic [7:0] pin_cfg_reg, pin_cfg_next;
  logic [7:0] enable_reg, enable_next;
  logic [7:0] mode_pri_reg, mode_pri_next;
  logic [7:0] mode_sec_reg, mode_sec_next;
  logic [7:0] flags_reg, flags_next;
  logic [7:0] rdata_reg, rdata_next;
  logic pin_oe_reg, pin_oe_next;
  logic [2:0] prox_ev_reg;
  logic [1:0] light_ev_reg;
  logic resp_ev_reg;
  logic [7:0] resp_val_reg;
  logic [2:0] prox_above, prox_change, prox_set, prox_clr;
  logic [1:0] light_in, light_change, light_set, light_clr;
  logic [7:0] set_vec, clr_vec;
  logic flags_wr, flags_rd;
  logic [2:0] prox_fire;
  sil_prox_mode_t pm;

  // saturating arithmetic keeps hysteresis bands inside the range
  function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] a,
                                            input logic [DW-1:0] b);
    logic [DW:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[DW] ? {DW{1'b1}} : s[DW-1:0];
  endfunction

  function automatic logic [DW-1:0] sat_sub(input logic [DW-1:0] a,
                                            input logic [DW-1:0] b);
    sat_sub = (a > b) ? a - b : '0;
  endfunction

  // mode field of proximity channel n
  function automatic sil_prox_mode_t prox_mode(input logic [7:0] pri,
                                               input logic [7:0] sec,
                                               input int n);
    logic [1:0] f;
    case (n)
      0: f = pri[`SIL_PROX_ONE_LSB +: 2];
      1: f = pri[`SIL_PROX_TWO_LSB +: 2];
      default: f = sec[`SIL_PROX_THREE_LSB +: 2];
    endcase
    prox_mode = sil_prox_mode_t'(f);
  endfunction

  // threshold trackers; hysteresis sets the band, history the count
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_prox
      assign prox_set[g] = prox_sample_in[g*DW +: DW] >
        sat_add(prox_threshold_in[g*DW +: DW], prox_hysteresis_in);
      assign prox_clr[g] = prox_sample_in[g*DW +: DW] <
        sat_sub(prox_threshold_in[g*DW +: DW], prox_hysteresis_in);
      sil_hist_filter #(.HW(HW)) u_prox (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .sample_in(prox_sample_valid_in[g]),
        .set_cond_in(prox_set[g]),
        .clr_cond_in(prox_clr[g]),
        .hist_len_in(prox_history_check_in),
        .state_out(prox_above[g]),
        .change_out(prox_change[g])
      );
    end
    for (g = 0; g < 2; g++) begin : g_light
      // entry needs the full band, exit only touching a bound
      assign light_set[g] =
        (light_sample_in[g*DW +: DW] >
         sat_add(light_low_threshold_in, light_hysteresis_in)) &&
        (sat_add(light_sample_in[g*DW +: DW], light_hysteresis_in) <
         light_high_threshold_in);
      assign light_clr[g] =
        (light_sample_in[g*DW +: DW] <= light_low_threshold_in) ||
        (light_sample_in[g*DW +: DW] >= light_high_threshold_in);
      sil_hist_filter #(.HW(HW)) u_light (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .sample_in(light_sample_valid_in[g]),
        .set_cond_in(light_set[g]),
        .clr_cond_in(light_clr[g]),
        .hist_len_in(light_history_in),
        .state_out(light_in[g]),
        .change_out(light_change[g])
      );
    end
  endgenerate

  // source events, delayed one cycle to line up with tracker outputs
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prox_ev_reg <= 3'h0;
      light_ev_reg <= 2'h0;
      resp_ev_reg <= 1'b0;
      resp_val_reg <= 8'h00;
    end else begin
      prox_ev_reg <= prox_sample_valid_in;
      light_ev_reg <= light_sample_valid_in;
      resp_ev_reg <= resp_valid_in;
      resp_val_reg <= resp_value_in;
    end
  end

  // which flags the sequencer raises this cycle
  always_comb begin
    set_vec = 8'h00;
    pm = SIL_PM_EVERY;
    prox_fire = 3'h0;
    for (int n = 0; n < 3; n++) begin
      pm = prox_mode(mode_pri_reg, mode_sec_reg, n);
      unique case (pm)
        SIL_PM_EVERY: prox_fire[n] = prox_ev_reg[n];
        SIL_PM_CROSS: prox_fire[n] = prox_change[n];
        SIL_PM_ABOVE: prox_fire[n] = prox_ev_reg[n] & prox_above[n];
        default: prox_fire[n] = 1'b0; // code 10 raises nothing
      endcase
      set_vec[`SIL_BIT_PROX_BASE + n] =
        enable_reg[`SIL_BIT_PROX_BASE + n] & prox_fire[n];
    end
    // light leave: per visible sample, or window exit of chosen channel
    set_vec[`SIL_BIT_LIGHT_LEAVE] = enable_reg[`SIL_BIT_LIGHT_LEAVE] &
      (((mode_pri_reg[2:0] == `SIL_LIGHT_EVERY) & light_ev_reg[0]) |
       (mode_pri_reg[`SIL_LIGHT_LEAVE_BIT] &
        light_change[mode_pri_reg[`SIL_LIGHT_CH_BIT]] &
        ~light_in[mode_pri_reg[`SIL_LIGHT_CH_BIT]]));
    set_vec[`SIL_BIT_LIGHT_ENTER] = enable_reg[`SIL_BIT_LIGHT_ENTER] &
      mode_pri_reg[`SIL_LIGHT_ENTER_BIT] &
      light_change[mode_pri_reg[`SIL_LIGHT_CH_BIT]] &
      light_in[mode_pri_reg[`SIL_LIGHT_CH_BIT]];
    set_vec[`SIL_BIT_CMD] = enable_reg[`SIL_BIT_CMD] & resp_ev_reg &
      (~mode_sec_reg[`SIL_CMD_SEL_BIT] |
       resp_val_reg[`SIL_RESP_ERR_BIT]);
  end

  // register writes, flag clearing and read data
  always_comb begin
    flags_wr = reg_wr_in && (reg_addr_in == `SIL_OFF_FLAGS);
    flags_rd = reg_rd_in && (reg_addr_in == `SIL_OFF_FLAGS);
    pin_cfg_next = pin_cfg_reg;
    enable_next = enable_reg;
    mode_pri_next = mode_pri_reg;
    mode_sec_next = mode_sec_reg;
    if (reg_wr_in) begin
      case (reg_addr_in)
        `SIL_OFF_PIN_CFG: pin_cfg_next = reg_wdata_in & `SIL_MASK_PIN_CFG;
        `SIL_OFF_ENABLE: enable_next = reg_wdata_in & `SIL_MASK_ENABLE;
        `SIL_OFF_MODE_PRI: mode_pri_next = reg_wdata_in & `SIL_MASK_MODE_PRI;
        `SIL_OFF_MODE_SEC: mode_sec_next = reg_wdata_in & `SIL_MASK_MODE_SEC;
        default: ;
      endcase
    end
    clr_vec = flags_wr ? reg_wdata_in : 8'h00;
    // read-release: a status read drops what it returned
    if (flags_rd &&
        sil_release_t'(pin_cfg_reg[`SIL_CFG_RELEASE]) == SIL_REL_READ) begin
      clr_vec = clr_vec | flags_reg;
    end
    // a set in the clearing cycle wins
    flags_next = ((flags_reg & ~clr_vec) | set_vec) & `SIL_MASK_FLAGS;
    rdata_next = rdata_reg;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `SIL_OFF_PIN_CFG: rdata_next = pin_cfg_reg;
        `SIL_OFF_ENABLE: rdata_next = enable_reg;
        `SIL_OFF_MODE_PRI: rdata_next = mode_pri_reg;
        `SIL_OFF_MODE_SEC: rdata_next = mode_sec_reg;
        `SIL_OFF_FLAGS: rdata_next = flags_reg;
        default: rdata_next = 8'h00;
      endcase
    end
    pin_oe_next = pin_cfg_reg[`SIL_CFG_OE] & |(enable_reg & flags_reg);
  end

  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pin_cfg_reg <= `SIL_RST_REG;
      enable_reg <= `SIL_RST_REG;
      mode_pri_reg <= `SIL_RST_REG;
      mode_sec_reg <= `SIL_RST_REG;
      flags_reg <= `SIL_RST_REG;
      rdata_reg <= `SIL_RST_REG;
      pin_oe_reg <= 1'b0;
    end else begin
      pin_cfg_reg <= pin_cfg_next;
      enable_reg <= enable_next;
      mode_pri_reg <= mode_pri_next;
      mode_sec_reg <= mode_sec_next;
      flags_reg <= flags_next;
      rdata_reg <= rdata_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  // the pin only ever pulls low; the board pulls it up
  assign irq_pin_n_out = 1'b0;
  assign irq_pin_oe_out = pin_oe_reg;
  assign reg_rdata_out = rdata_reg;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_pin_off;
    !pin_cfg_reg[`SIL_CFG_OE] |=> !irq_pin_oe_out;
  endproperty
  a_pin_off: assert property (p_pin_off)
    else $error("pin driven with output enable clear");

  property p_pin_on;
    pin_cfg_reg[`SIL_CFG_OE] && |(enable_reg & flags_reg) |=> irq_pin_oe_out;
  endproperty
  a_pin_on: assert property (p_pin_on)
    else $error("pin not driven for enabled flag");

  property p_hold;
    !flags_wr && !pin_cfg_reg[`SIL_CFG_RELEASE]
      |=> (flags_reg & $past(flags_reg)) == $past(flags_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("flag dropped without host clear");

  property p_w1c;
    flags_wr && set_vec == 8'h00 && !flags_rd
      |=> flags_reg == ($past(flags_reg) & ~$past(reg_wdata_in) & 8'h3F);
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write-one-clear mismatch");

  property p_read_release;
    flags_rd && pin_cfg_reg[`SIL_CFG_RELEASE] && set_vec == 8'h00
      |=> flags_reg == 8'h00;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("read release left flags set");

  property p_disabled;
    1'b1 |=> (flags_reg & ~$past(flags_reg) & ~$past(enable_reg)) == 8'h00;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("disabled channel raised its flag");

  property p_every;
    (enable_reg[2] && mode_pri_reg[5:4] == 2'b00 && prox_sample_valid_in[0])
      ##1 (enable_reg[2] && mode_pri_reg[5:4] == 2'b00) |=> flags_reg[2];
  endproperty
  a_every: assert property (p_every)
    else $error("per-sample flag missing");

  property p_cross;
    enable_reg[2] && mode_pri_reg[5:4] == 2'b01 && prox_change[0]
      |=> flags_reg[2];
  endproperty
  a_cross: assert property (p_cross)
    else $error("crossing flag missing");

  property p_above;
    enable_reg[2] && mode_pri_reg[5:4] == 2'b11 && prox_ev_reg[0] &&
      prox_above[0] |=> flags_reg[2];
  endproperty
  a_above: assert property (p_above)
    else $error("above-threshold flag missing");

  property p_cmd;
    enable_reg[5] && resp_ev_reg && resp_val_reg[7] |=> flags_reg[5];
  endproperty
  a_cmd: assert property (p_cmd)
    else $error("command error flag missing");

  property p_history;
    prox_change[0] |-> $past(prox_sample_valid_in[0]);
  endproperty
  a_history: assert property (p_history)
    else $error("crossing without a sample");

  c_pin: cover property (!irq_pin_oe_out ##1 irq_pin_oe_out);
  c_cross: cover property (prox_change[0] && enable_reg[2]);
  c_light_enter: cover property (set_vec[1]);
  c_set_clear: cover property (flags_wr && |(set_vec & reg_wdata_in));
endmodule
`default_nettype wire

// ==== tb/sil_host_model.sv ====
// host side model: single byte reads and writes on the register port
// assumes the bench calls its tasks; lines move at the falling edge
`default_nettype none
`include "sil_cfg.svh"
module sil_host_model (
  // clock
  input wire logic core_clk_in,
  // register port
  output logic [7:0] reg_addr_out,
  output logic [7:0] reg_wdata_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  input wire logic [7:0] reg_rdata_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle bus at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
  end
  // one-cycle write strobe; idle lines show the inverse, never stale data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge core_clk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  // read data lands one edge after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge core_clk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    @(negedge core_clk_in);
    d = reg_rdata_out_q();
  endtask
  function automatic logic [7:0] reg_rdata_out_q();
    return reg_rdata_in;
  endfunction
  // service routine: keep a copy of the flags, write it back
  task automatic service(output logic [7:0] seen);
    rd(`SIL_OFF_FLAGS, seen);
    wr(`SIL_OFF_FLAGS, seen);
  endtask
endmodule
`default_nettype wire

// ==== tb/sensor_interrupt_logic_tb_top.sv ====
// self-checking bench of the sensor interrupt logic
// assumes sil_irq_core with default widths and the host model beside it
`default_nettype none
`include "sil_cfg.svh"
module sensor_interrupt_logic_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr, wdata, rdata, seen;
  logic wr, rd, irq_n, irq_oe, resp_valid;
  logic [7:0] resp_value = 8'h00;
  logic [2:0] prox_valid = 3'h0;
  logic [1:0] light_valid = 2'h0;
  logic [47:0] prox_sample = 48'h0, prox_th = 48'h0;
  logic [31:0] light_sample = 32'h0;
  logic [15:0] low_th = 16'h0064, high_th = 16'h00C8;
  logic [15:0] prox_hyst = 16'h0000;
  logic [3:0] prox_hist = 4'h1;
  int num_errors = 0;
  int n_compared = 0;
  int cycles = 0;
  initial resp_valid = 1'b0;
  always #2.5 clk = ~clk;
  sil_host_model i_host (.core_clk_in(clk), .reg_addr_out(addr),
    .reg_wdata_out(wdata), .reg_wr_out(wr), .reg_rd_out(rd),
    .reg_rdata_in(rdata));
  // light hysteresis zero and history one keep its window exact
  sil_irq_core i_dut (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
    .reg_rdata_out(rdata), .prox_sample_valid_in(prox_valid),
    .prox_sample_in(prox_sample), .prox_threshold_in(prox_th),
    .prox_hysteresis_in(prox_hyst), .prox_history_check_in(prox_hist),
    .light_sample_valid_in(light_valid), .light_sample_in(light_sample),
    .light_low_threshold_in(low_th), .light_high_threshold_in(high_th),
    .light_hysteresis_in(16'h0000), .light_history_in(4'h1),
    .resp_valid_in(resp_valid), .resp_value_in(resp_value),
    .irq_pin_n_out(irq_n), .irq_pin_oe_out(irq_oe));
  task automatic stop_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic chk8(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk1(string what, logic exp, logic got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] exp);
    i_host.rd(a, seen);
    chk8($sformatf("reg %h", a), exp, seen);
  endtask
  // kind 0 prox, 1 light, 2 response; waits until the pin has settled
  task automatic strobe(int kind, int ch, logic [15:0] v);
    @(negedge clk);
    case (kind)
      0: begin
        prox_sample[ch*16 +: 16] = v;
        prox_valid[ch] = 1'b1;
      end
      1: begin
        light_sample[ch*16 +: 16] = v;
        light_valid[ch] = 1'b1;
      end
      default: begin
        resp_value = v[7:0];
        resp_valid = 1'b1;
      end
    endcase
    @(negedge clk);
    prox_valid = 3'h0;
    light_valid = 2'h0;
    resp_valid = 1'b0;
    resp_value = ~resp_value;
    repeat (3) @(negedge clk);
  endtask
  task automatic setup(logic [7:0] cfg, en, mp, ms);
    i_host.wr(`SIL_OFF_PIN_CFG, cfg);
    i_host.wr(`SIL_OFF_ENABLE, en);
    i_host.wr(`SIL_OFF_MODE_PRI, mp);
    i_host.wr(`SIL_OFF_MODE_SEC, ms);
    i_host.wr(`SIL_OFF_FLAGS, 8'hFF);
  endtask
  // reset values, writable bits, unmapped offset
  task automatic t_regs();
    logic [7:0] offs [6];
    logic [7:0] msk [6];
    offs = '{`SIL_OFF_PIN_CFG, `SIL_OFF_ENABLE, `SIL_OFF_MODE_PRI,
      `SIL_OFF_MODE_SEC, `SIL_OFF_FLAGS, 8'h20};
    msk = '{`SIL_MASK_PIN_CFG, `SIL_MASK_ENABLE, `SIL_MASK_MODE_PRI,
      `SIL_MASK_MODE_SEC, 8'h00, 8'h00};
    for (int i = 0; i < 6; i++) begin
      rd_chk(offs[i], 8'h00);
      i_host.wr(offs[i], 8'hFF);
      rd_chk(offs[i], msk[i]);
      i_host.wr(offs[i], 8'h00);
    end
  endtask
  task automatic t_every();
    setup(8'h01, 8'h1C, 8'h00, 8'h00);
    strobe(0, 0, 16'h0005);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
    chk1("pin enable", 1'b1, irq_oe);
    chk1("pin level", 1'b0, irq_n);
    strobe(0, 1, 16'h0005);
    strobe(0, 2, 16'h0005);
    rd_chk(`SIL_OFF_FLAGS, 8'h1C);
    i_host.wr(`SIL_OFF_FLAGS, 8'h04);
    rd_chk(`SIL_OFF_FLAGS, 8'h18);
    i_host.service(seen);
    chk8("serviced", 8'h18, seen);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    chk1("pin after clear", 1'b0, irq_oe);
  endtask
  task automatic t_oe();
    setup(8'h00, 8'h04, 8'h00, 8'h00);
    strobe(0, 0, 16'h0005);
    chk1("pin off", 1'b0, irq_oe);
    i_host.wr(`SIL_OFF_PIN_CFG, 8'h01);
    repeat (2) @(negedge clk);
    chk1("pin on", 1'b1, irq_oe);
    i_host.wr(`SIL_OFF_ENABLE, 8'h00);
    repeat (2) @(negedge clk);
    chk1("pin masked", 1'b0, irq_oe);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
  endtask
  task automatic t_masked();
    setup(8'h01, 8'h00, 8'h00, 8'h00);
    strobe(0, 0, 16'h0005);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    setup(8'h01, 8'h04, 8'h20, 8'h00);
    strobe(0, 0, 16'h0005);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
  endtask
  task automatic t_thresh();
    prox_th[15:0] = 16'h0064;
    // earlier tests left the tracker above; bring it below first
    strobe(0, 0, 16'h0032);
    setup(8'h01, 8'h04, 8'h10, 8'h00);
    strobe(0, 0, 16'h0096);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
    i_host.wr(`SIL_OFF_FLAGS, 8'h04);
    strobe(0, 0, 16'h00A0);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    strobe(0, 0, 16'h0032);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
    setup(8'h01, 8'h04, 8'h30, 8'h00);
    strobe(0, 0, 16'h0028);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    strobe(0, 0, 16'h0096);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
    i_host.wr(`SIL_OFF_FLAGS, 8'h04);
    strobe(0, 0, 16'h00A0);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
    // band of ten below threshold, two agreeing samples per flip
    prox_hyst = 16'h000A;
    prox_hist = 4'h2;
    setup(8'h01, 8'h04, 8'h10, 8'h00);
    strobe(0, 0, 16'h005F);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    strobe(0, 0, 16'h0050);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    strobe(0, 0, 16'h0050);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
  endtask
  task automatic t_light_cmd();
    setup(8'h01, 8'h01, 8'h00, 8'h00);
    strobe(1, 0, 16'h0010);
    rd_chk(`SIL_OFF_FLAGS, 8'h01);
    setup(8'h01, 8'h02, 8'h04, 8'h00);
    strobe(1, 0, 16'h0096);
    rd_chk(`SIL_OFF_FLAGS, 8'h02);
    // window exit on visible, then entry on infrared
    setup(8'h01, 8'h01, 8'h01, 8'h00);
    strobe(1, 0, 16'h0010);
    rd_chk(`SIL_OFF_FLAGS, 8'h01);
    setup(8'h01, 8'h02, 8'h06, 8'h00);
    strobe(1, 1, 16'h0096);
    rd_chk(`SIL_OFF_FLAGS, 8'h02);
    setup(8'h01, 8'h20, 8'h00, 8'h04);
    strobe(2, 0, 16'h0001);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
    strobe(2, 0, 16'h0080);
    rd_chk(`SIL_OFF_FLAGS, 8'h20);
    setup(8'h01, 8'h20, 8'h00, 8'h00);
    strobe(2, 0, 16'h0001);
    rd_chk(`SIL_OFF_FLAGS, 8'h20);
  endtask
  task automatic t_release();
    setup(8'h03, 8'h04, 8'h00, 8'h00);
    strobe(0, 0, 16'h0005);
    chk1("pin read mode", 1'b1, irq_oe);
    rd_chk(`SIL_OFF_FLAGS, 8'h04);
    repeat (2) @(negedge clk);
    chk1("pin read clear", 1'b0, irq_oe);
    rd_chk(`SIL_OFF_FLAGS, 8'h00);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    t_regs();
    t_every();
    t_oe();
    t_masked();
    t_thresh();
    t_light_cmd();
    t_release();
    stop_test();
  end
endmodule
`default_nettype wire
